// >>> logic/wdrl_top.v
// Watchdog reload lock registers with 24-bit down-counter, Avalon-MM slave.
// Assumes one ref_clk domain; oscillator tick arrives asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "wdrl_regs.vh"

module wdrl_top #(
	parameter ADDR_W = 14
) (
	// Clock and reset.
	input  wire              ref_clk,
	input  wire              nrst,
	// Avalon-MM slave.
	input  wire [ADDR_W-1:0] avs_address,
	input  wire              avs_read,
	input  wire              avs_write,
	input  wire [31:0]       avs_writedata,
	input  wire [3:0]        avs_byteenable,
	output reg  [31:0]       avs_readdata,
	output reg               avs_waitrequest,
	// Watchdog events.
	input  wire              osc_tick,
	input  wire              stop_mode,
	input  wire              refresh_instruction,
	output reg               timeout_pulse,
	output reg               timeout_reset,
	output reg               irq
);

	////////////////////////////////////////////////////////////////////////
	// Lock states.
	localparam [4:0] LK_IDLE  = 5'b00001;
	localparam [4:0] LK_KEY1  = 5'b00010;
	localparam [4:0] LK_UPPER = 5'b00100;
	localparam [4:0] LK_MID   = 5'b01000;
	localparam [4:0] LK_LOW   = 5'b10000;

	reg  [4:0]  lock_reg;
	reg  [4:0]  lock_next;
	reg  [7:0]  upper_reg;
	reg  [7:0]  middle_reg;
	reg  [7:0]  low_reg;
	reg  [23:0] count_reg;
	reg  [23:0] count_next;
	reg         enable_reg;
	reg         int_mode_reg;
	reg  [1:0]  cause_reg;
	reg  [`WDRL_IRQ_WIDTH-1:0] irq_stat_reg;
	reg  [`WDRL_IRQ_WIDTH-1:0] irq_en_reg;
	reg         tick_prev_reg;
	reg         ack_reg;
	reg  [31:0] rdata_next;

	wire        tick_lvl;
	wire        stop_lvl;
	wire        tick_rise;
	wire [11:0] idx;
	wire        wr;
	wire        rd;
	wire        bus_req;
	wire        ctl_wr;
	wire        en_wr;
	wire        clr_wr;
	wire        cause_rd;
	wire        key1_hit;
	wire        key2_hit;
	wire        reload_hit;
	wire        irq_any;
	wire [7:0]  wbyte;
	wire [23:0] reload_val;
	wire        refresh_ok;
	wire        hit_zero;
	wire        wr_upper;
	wire        wr_mid;
	wire        wr_low;
	wire        refused;
	wire [`WDRL_IRQ_WIDTH-1:0] irq_event;

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for the oscillator tick and stop indication.
	wdrl_sync u_sync_tick (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.async_in  (osc_tick),
		.level_out (tick_lvl)
	);

	wdrl_sync u_sync_stop (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.async_in  (stop_mode),
		.level_out (stop_lvl)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus decode; a request is taken once, then waitrequest drops for a cycle.
	assign idx     = avs_address[11:0];
	assign bus_req = avs_read || avs_write;
	// A write commits at the edge where the master sees waitrequest low.
	assign wr      = avs_write && ack_reg;
	// A read is taken one edge earlier, so its data stand at that edge.
	assign rd      = avs_read && !ack_reg;
	assign wbyte   = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

	assign ctl_wr   = wr && (idx == `WDRL_IDX_CONTROL) &&
		avs_byteenable[0];
	assign en_wr    = wr && (idx == `WDRL_IDX_IRQ_ENABLE) &&
		avs_byteenable[0];
	assign clr_wr   = wr && (idx == `WDRL_IDX_IRQ_CLEAR) &&
		avs_byteenable[0];
	assign cause_rd = rd && (idx == `WDRL_IDX_UNLOCK);
	assign key1_hit = (idx == `WDRL_IDX_UNLOCK) &&
		(wbyte == `WDRL_KEY_FIRST);
	assign key2_hit = (idx == `WDRL_IDX_UNLOCK) &&
		(wbyte == `WDRL_KEY_SECOND);
	assign reload_hit = (idx == `WDRL_IDX_UPPER) ||
		(idx == `WDRL_IDX_MIDDLE) || (idx == `WDRL_IDX_LOW);

	assign wr_upper = wr && (idx == `WDRL_IDX_UPPER) && lock_reg == LK_UPPER;
	assign wr_mid   = wr && (idx == `WDRL_IDX_MIDDLE) && lock_reg == LK_MID;
	assign wr_low   = wr && (idx == `WDRL_IDX_LOW) && lock_reg == LK_LOW;
	assign refused  = wr && reload_hit &&
		!wr_upper && !wr_mid && !wr_low;

	////////////////////////////////////////////////////////////////////////
	// Handshake; waitrequest drops for exactly one cycle per request.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ack_reg         <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			ack_reg         <= bus_req && !ack_reg;
			avs_waitrequest <= !(bus_req && !ack_reg);
		end
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			avs_readdata <= 32'h0;
		else if (rd)
			avs_readdata <= rdata_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Lock state machine.
	always @* begin
		lock_next = lock_reg;
		if (wr) begin
			case (lock_reg)
			LK_IDLE: begin
				if (key1_hit)
					lock_next = LK_KEY1;
			end
			LK_KEY1: begin
				if (key2_hit)
					lock_next = LK_UPPER;
				else
					lock_next = LK_IDLE;
			end
			LK_UPPER: lock_next = wr_upper ? LK_MID : LK_IDLE;
			LK_MID:   lock_next = wr_mid ? LK_LOW : LK_IDLE;
			LK_LOW:   lock_next = LK_IDLE;
			default:  lock_next = LK_IDLE;
			endcase
		end
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lock_reg   <= LK_IDLE;
			upper_reg  <= `WDRL_RST_UPPER;
			middle_reg <= `WDRL_RST_MIDDLE;
			low_reg    <= `WDRL_RST_LOW;
		end else begin
			lock_reg <= lock_next;
			if (wr_upper)
				upper_reg <= wbyte;
			if (wr_mid)
				middle_reg <= wbyte;
			if (wr_low)
				low_reg <= wbyte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Down-counter.
	assign reload_val = {upper_reg, middle_reg, low_reg};
	assign tick_rise  = tick_lvl && !tick_prev_reg;
	assign refresh_ok = refresh_instruction &&
		(!enable_reg || count_reg > `WDRL_CNT_NO_REFRESH);
	assign hit_zero   = enable_reg && !refresh_ok && tick_rise &&
		count_reg == (`WDRL_CNT_ZERO + 24'h000001);

	always @* begin
		count_next = count_reg;
		if (refresh_ok)
			count_next = reload_val;
		else if (enable_reg && tick_rise) begin
			if (count_reg == `WDRL_CNT_ZERO)
				count_next = `WDRL_CNT_MAX;
			else
				count_next = count_reg - 24'h000001;
		end
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			count_reg     <= {`WDRL_RST_UPPER, `WDRL_RST_MIDDLE,
				`WDRL_RST_LOW};
			tick_prev_reg <= 1'b0;
			timeout_pulse <= 1'b0;
			timeout_reset <= 1'b0;
		end else begin
			tick_prev_reg <= tick_lvl;
			count_reg     <= count_next;
			timeout_pulse <= hit_zero;
			timeout_reset <= hit_zero && !int_mode_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset cause; a time-out in the cycle of a read of it wins.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cause_reg <= 2'h0;
		end else if (hit_zero) begin
			cause_reg[`WDRL_CAUSE_TIMEOUT] <= 1'b1;
			cause_reg[`WDRL_CAUSE_STOP]    <= stop_lvl;
		end else if (cause_rd) begin
			cause_reg <= 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register; a refresh instruction also enables the counter.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			enable_reg   <= 1'b0;
			int_mode_reg <= 1'b1;
		end else begin
			if (refresh_instruction)
				enable_reg <= 1'b1;
			else if (ctl_wr)
				enable_reg <= avs_writedata[`WDRL_CTL_ENABLE];
			if (ctl_wr)
				int_mode_reg <= avs_writedata[`WDRL_CTL_INT_MODE];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status, enable and clear; a set wins over a clear.
	assign irq_event[`WDRL_IRQ_TIMEOUT] = hit_zero;
	assign irq_event[`WDRL_IRQ_REFUSED] = refused;
	assign irq_any = |(irq_stat_reg & irq_en_reg);

	genvar gi;
	generate
		for (gi = 0; gi < `WDRL_IRQ_WIDTH; gi = gi + 1) begin : g_irq
			always @(posedge ref_clk or negedge nrst) begin
				if (!nrst)
					irq_stat_reg[gi] <= 1'b0;
				else if (irq_event[gi])
					irq_stat_reg[gi] <= 1'b1;
				else if (clr_wr && avs_writedata[gi])
					irq_stat_reg[gi] <= 1'b0;
			end
		end
	endgenerate

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq_en_reg <= {`WDRL_IRQ_WIDTH{1'b0}};
			irq        <= 1'b0;
		end else begin
			if (en_wr)
				irq_en_reg <= avs_writedata[`WDRL_IRQ_WIDTH-1:0];
			irq <= irq_any;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux.
	always @* begin
		rdata_next = 32'h0;
		case (idx)
		`WDRL_IDX_UNLOCK:     rdata_next = {30'h0, cause_reg};
		`WDRL_IDX_UPPER:      rdata_next = {24'h0, count_reg[23:16]};
		`WDRL_IDX_MIDDLE:     rdata_next = {24'h0, count_reg[15:8]};
		`WDRL_IDX_LOW:        rdata_next = {24'h0, count_reg[7:0]};
		`WDRL_IDX_IRQ_STATUS: rdata_next = {30'h0, irq_stat_reg};
		`WDRL_IDX_IRQ_ENABLE: rdata_next = {30'h0, irq_en_reg};
		`WDRL_IDX_CONTROL:    rdata_next = {30'h0, int_mode_reg, enable_reg};
		default:              rdata_next = 32'h0;
		endcase
	end

endmodule // wdrl_top
`default_nettype wire

// >>> logic/wdrl_regs.vh
// Register offsets, field positions, reset values and timing counts of the
// watchdog reload lock block.
// Assumes a word-addressed Avalon-MM slave; byte address is four times index.
`ifndef WDRL_REGS_VH
`define WDRL_REGS_VH

// Offsets are register indices; byte address is index times four.
`define WDRL_IDX_UNLOCK      12'hff0
`define WDRL_IDX_UPPER       12'hff1
`define WDRL_IDX_MIDDLE      12'hff2
`define WDRL_IDX_LOW         12'hff3
`define WDRL_IDX_IRQ_STATUS  12'hff4
`define WDRL_IDX_IRQ_ENABLE  12'hff5
`define WDRL_IDX_IRQ_CLEAR   12'hff6
`define WDRL_IDX_CONTROL     12'hff7

// Unlock keys.
`define WDRL_KEY_FIRST       8'h55
`define WDRL_KEY_SECOND      8'haa

// Reset values of the reload bytes.
`define WDRL_RST_UPPER       8'h00
`define WDRL_RST_MIDDLE      8'h04
`define WDRL_RST_LOW         8'h00

// Counter landmarks.
`define WDRL_CNT_ZERO        24'h000000
`define WDRL_CNT_NO_REFRESH  24'h000002
`define WDRL_CNT_MAX         24'hffffff

// Reset cause status bits.
`define WDRL_CAUSE_TIMEOUT   0
`define WDRL_CAUSE_STOP      1

// Interrupt status bits.
`define WDRL_IRQ_TIMEOUT     0
`define WDRL_IRQ_REFUSED     1
`define WDRL_IRQ_WIDTH       2

// Control register fields.
`define WDRL_CTL_ENABLE      0
`define WDRL_CTL_INT_MODE    1

// Synchroniser depth for oscillator tick and stop inputs.
`define WDRL_SYNC_STAGES     3

`endif

// >>> logic/wdrl_sync.v
// Three-stage synchroniser with agreement filter for one asynchronous level.
// Assumes input from another clock domain; output is registered in ref_clk.
`timescale 1ns/1ps
`default_nettype none

module wdrl_sync (
	// Clock and reset.
	input  wire ref_clk,
	input  wire nrst,
	// Level in and out.
	input  wire async_in,
	output reg  level_out
);

	reg  [2:0] stage_reg;

	// The first stage feeds only the second; agreement of two and three counts.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stage_reg <= 3'h0;
			level_out <= 1'b0;
		end else begin
			stage_reg <= {stage_reg[1:0], async_in};
			if (stage_reg[1] == stage_reg[2])
				level_out <= stage_reg[2];
		end
	end

endmodule // wdrl_sync
`default_nettype wire

// >>> testbench/wdrl_asserts.sv
// Concurrent checks on the ports of the watchdog reload lock block.
// Assumes one ref_clk domain and an active-low asynchronous nrst.
`timescale 1ns/1ps
`default_nettype none
module wdrl_asserts (
	// Clock and reset.
	input wire logic        ref_clk,
	input wire logic        nrst,
	// Register bus.
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Events.
	input wire logic        timeout_pulse,
	input wire logic        timeout_reset,
	input wire logic        irq
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!nrst);
logic [3:0] since_reg;
always @(posedge ref_clk or negedge nrst)
	if (!nrst) since_reg <= 4'hf;
	else if (avs_write | timeout_pulse) since_reg <= 4'h0;
	else if (since_reg != 4'hf) since_reg <= since_reg + 4'h1;
sequence s_ack;
	!avs_waitrequest ##1 avs_waitrequest;
endsequence
a_rd_ack: assert property ($rose(avs_read) |=> s_ack)
	else $error("read not answered in one cycle");
a_wr_ack: assert property ($rose(avs_write) |=> s_ack)
	else $error("write not answered in one cycle");
a_no_spur: assert property (!avs_read && !avs_write && avs_waitrequest
	|=> avs_waitrequest) else $error("answer without request");
a_one_ack: assert property (!avs_waitrequest |=> avs_waitrequest)
	else $error("answer longer than one cycle");
a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
	else $error("read data changed without read");
a_pulse_one: assert property (timeout_pulse |=> !timeout_pulse)
	else $error("time-out pulse too long");
a_reset_pair: assert property (timeout_reset |-> timeout_pulse)
	else $error("reset request without time-out");
a_irq_cause: assert property ($rose(irq) |-> since_reg <= 4'h3)
	else $error("interrupt without cause");
endmodule // wdrl_asserts
bind wdrl_top wdrl_asserts wdrl_asserts_inst (.ref_clk(ref_clk),
	.nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.timeout_pulse(timeout_pulse), .timeout_reset(timeout_reset),
	.irq(irq));
`default_nettype wire

// >>> testbench/wdrl_osc_model.sv
// Low-rate oscillator model feeding the watchdog count input.
// Assumes ref_clk at 100 MHz; ticks only while run is high.
`timescale 1ns/1ps
`default_nettype none
module wdrl_osc_model (
	// Clock and control.
	input wire logic ref_clk,
	input wire logic run,
	// Oscillator output.
	output var logic osc_tick
);
logic [1:0] div_reg;
initial div_reg = 2'h0;
initial osc_tick = 1'b0;
always @(posedge ref_clk) begin
	div_reg <= div_reg + 2'h1;
	if (run && div_reg == 2'h3) osc_tick <= !osc_tick;
end
endmodule // wdrl_osc_model
`default_nettype wire

// >>> testbench/wdrl_top_tb.sv
// Self-checking bench for the watchdog reload lock block.
// Assumes the register header and an oscillator model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "wdrl_regs.vh"
module wdrl_top_tb;
logic        ref_clk, nrst, avs_read, avs_write, run, refresh_instruction;
logic        avs_waitrequest, osc_tick, timeout_pulse, timeout_reset, irq;
logic        stop_mode;
logic [13:0] avs_address;
logic [31:0] avs_writedata, avs_readdata, seed;
logic [7:0]  exp_q[$];
int          err_count, cmp_count;
wdrl_top wdrl_top_inst (.ref_clk(ref_clk), .nrst(nrst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(4'hf),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.osc_tick(osc_tick), .stop_mode(stop_mode),
	.refresh_instruction(refresh_instruction),
	.timeout_pulse(timeout_pulse), .timeout_reset(timeout_reset), .irq(irq));
wdrl_osc_model wdrl_osc_model_inst (.ref_clk(ref_clk), .run(run),
	.osc_tick(osc_tick));
////////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] xs(input logic [31:0] s);
	s = s ^ (s << 13);
	s = s ^ (s >> 17);
	return s ^ (s << 5);
endfunction
task automatic bus(input logic wr, input logic [11:0] idx,
	input logic [7:0] d);
	@(posedge ref_clk);
	avs_address <= {2'b00, idx};
	avs_writedata <= {24'h000000, d};
	avs_read <= !wr;
	avs_write <= wr;
	do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
	avs_read <= 1'b0;
	avs_write <= 1'b0;
endtask
task automatic rd(input logic [11:0] idx, input logic [7:0] e);
	exp_q.push_back(e);
	bus(1'b0, idx, 8'h00);
endtask
task automatic load(input logic [23:0] v);
	bus(1'b1, `WDRL_IDX_UNLOCK, `WDRL_KEY_FIRST);
	bus(1'b1, `WDRL_IDX_UNLOCK, `WDRL_KEY_SECOND);
	bus(1'b1, `WDRL_IDX_UPPER, v[23:16]);
	bus(1'b1, `WDRL_IDX_MIDDLE, v[15:8]);
	bus(1'b1, `WDRL_IDX_LOW, v[7:0]);
endtask
task automatic refresh;
	@(posedge ref_clk);
	refresh_instruction <= 1'b1;
	@(posedge ref_clk);
	refresh_instruction <= 1'b0;
endtask
task automatic chk(input logic got, input logic exp);
	cmp_count++;
	if (got !== exp) begin
		err_count++;
		$display("CHECK FAILED t=%0t flag got %b exp %b", $time, got, exp);
	end
endtask
task automatic tally_and_finish;
	$display("mismatches %0d compares %0d", err_count, cmp_count);
	if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
	else $display("DONE - FAIL");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////
// Read results are compared in order against the queued expectations.
always @(posedge ref_clk)
	if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
		cmp_count++;
		if (avs_readdata[7:0] !== exp_q[0]) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time,
				avs_readdata[7:0], exp_q[0]);
		end
		void'(exp_q.pop_front());
	end
initial begin
	ref_clk = 1'b0;
	forever #5 ref_clk = ~ref_clk;
end
initial begin
	#60000;
	err_count++;
	tally_and_finish;
end
initial begin
	nrst = 1'b0;
	avs_read = 1'b0;
	avs_write = 1'b0;
	avs_address = 14'h0000;
	avs_writedata = 32'h00000000;
	run = 1'b0;
	stop_mode = 1'b0;
	refresh_instruction = 1'b0;
	seed = xs(32'h0001060f);
	repeat (12) @(posedge ref_clk);
	nrst <= 1'b1;
	rd(`WDRL_IDX_UPPER, `WDRL_RST_UPPER);
	rd(`WDRL_IDX_MIDDLE, `WDRL_RST_MIDDLE);
	rd(`WDRL_IDX_LOW, `WDRL_RST_LOW);
	bus(1'b1, `WDRL_IDX_IRQ_ENABLE, 8'h03);
	bus(1'b1, `WDRL_IDX_UPPER, seed[7:0]);
	rd(`WDRL_IDX_IRQ_STATUS, 8'h02);
	chk(irq, 1'b1);
	bus(1'b1, `WDRL_IDX_IRQ_CLEAR, 8'h03);
	bus(1'b1, `WDRL_IDX_UNLOCK, `WDRL_KEY_FIRST);
	chk(irq, 1'b0);
	bus(1'b1, `WDRL_IDX_UNLOCK, `WDRL_KEY_SECOND);
	bus(1'b1, `WDRL_IDX_UPPER, seed[15:8]);
	bus(1'b1, `WDRL_IDX_IRQ_ENABLE, 8'h03);
	bus(1'b1, `WDRL_IDX_MIDDLE, seed[23:16]);
	rd(`WDRL_IDX_IRQ_STATUS, 8'h02);
	bus(1'b1, `WDRL_IDX_IRQ_CLEAR, 8'h03);
	seed = xs(seed);
	load({seed[7:0], seed[15:8], 8'h10});
	rd(`WDRL_IDX_IRQ_STATUS, 8'h00);
	rd(`WDRL_IDX_UNLOCK, 8'h00);
	refresh;
	rd(`WDRL_IDX_UPPER, seed[7:0]);
	rd(`WDRL_IDX_MIDDLE, seed[15:8]);
	rd(`WDRL_IDX_LOW, 8'h10);
	bus(1'b1, `WDRL_IDX_LOW, 8'h77);
	rd(`WDRL_IDX_IRQ_STATUS, 8'h02);
	bus(1'b1, `WDRL_IDX_IRQ_CLEAR, 8'h03);
	load(24'h000008);
	refresh;
	run <= 1'b1;
	do @(posedge ref_clk); while (timeout_pulse !== 1'b1);
	chk(timeout_reset, 1'b0);
	repeat (20) @(posedge ref_clk);
	run <= 1'b0;
	rd(`WDRL_IDX_IRQ_STATUS, 8'h01);
	chk(irq, 1'b1);
	rd(`WDRL_IDX_UNLOCK, 8'h01);
	rd(`WDRL_IDX_UPPER, 8'hff);
	bus(1'b1, `WDRL_IDX_IRQ_CLEAR, 8'h03);
	rd(`WDRL_IDX_IRQ_STATUS, 8'h00);
	chk(irq, 1'b0);
	bus(1'b1, `WDRL_IDX_CONTROL, 8'h01);
	stop_mode <= 1'b1;
	load(24'h000004);
	refresh;
	run <= 1'b1;
	do @(posedge ref_clk); while (timeout_pulse !== 1'b1);
	run <= 1'b0;
	chk(timeout_reset, 1'b1);
	refresh;
	rd(`WDRL_IDX_LOW, 8'h00);
	rd(`WDRL_IDX_UNLOCK, 8'h03);
	repeat (4) @(posedge ref_clk);
	tally_and_finish;
end
endmodule // wdrl_top_tb
`default_nettype wire
